//--- design/sfrr_regs.vh
`ifndef SFRR_REGS_VH
`define SFRR_REGS_VH
// Clock rate
`define SFRR_CLK_MHZ          250
// Timing figures in their own units
`define SFRR_CLEAR_MIN_US     10
`define SFRR_REC_POWER_US     35
`define SFRR_REC_READ_US      35
`define SFRR_REC_DECODE_US    40
`define SFRR_REC_PROGRAM_US   310
`define SFRR_REC_SECTOR_MS    12
`define SFRR_REC_BLOCK_MS     25
`define SFRR_REC_CHIP_MS      100
`define SFRR_REC_STATUS_MS    40
`define SFRR_PDN_ENTRY_US     10
`define SFRR_PDN_EXIT_US      30
`define SFRR_PAGE_TYP_US      250
`define SFRR_SECTOR_TYP_MS    30
`define SFRR_BLOCK_TYP_MS     380
`define SFRR_CHIP_TYP_S       110
`define SFRR_STATUS_MAX_MS    40
// Derived cycle counts
`define SFRR_CLEAR_MIN_CYC    (`SFRR_CLEAR_MIN_US * `SFRR_CLK_MHZ)
`define SFRR_PDN_ENTRY_CYC    (`SFRR_PDN_ENTRY_US * `SFRR_CLK_MHZ)
`define SFRR_PDN_EXIT_CYC     (`SFRR_PDN_EXIT_US * `SFRR_CLK_MHZ)
// Operation codes
`define SFRR_OP_NONE          3'h0
`define SFRR_OP_READ          3'h1
`define SFRR_OP_DECODE        3'h2
`define SFRR_OP_PROGRAM       3'h3
`define SFRR_OP_SECTOR        3'h4
`define SFRR_OP_BLOCK         3'h5
`define SFRR_OP_CHIP          3'h6
`define SFRR_OP_STATUS        3'h7
// Counter width
`define SFRR_CNT_W            40
`endif

//--- design/sfrr_sync.v
`timescale 1ns/1ps
module sfrr_sync (
  // Clock and reset
  input  wire       mclk_i,
  input  wire       reset_n_i,
  // Asynchronous levels
  input  wire [3:0] async_i,
  output reg  [3:0] sync_o
);
  reg [3:0] stage1;

  always @(posedge mclk_i) begin
    if (!reset_n_i) begin
      // Idle pin levels, so no false link clock edge follows reset
      stage1 <= 4'hb;
      sync_o <= 4'hb;
    end else begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end
endmodule // sfrr_sync

//--- design/sfrr_core.v
// Summary of operation
// RL1: Clear pin low ten microseconds resets device
// RL2: Reset returns standby, clears latch, flags
// RL3: Reset aborts running program or erase
// RL4: Data output tristated during reset cycle
// RL5: Suspended erase sets recovery from erase
// RL6: Recovery delay chosen by interrupted activity
// RL7: Host holds clear high before select
// RL8: Power-up lands standby, latch cleared
// RL9: Host leaves device deselected during power-up
// RL10: Supply-to-operation delay at least 3000 us; code waits REC_POWER_CYC, 35 us, once supply is good
// RL11: Below inhibit threshold, logic held, commands ignored
// RL12: Program resume-to-suspend spacing at least 0.3 us; code accepts a suspend on any busy cycle
// RL13: Erase resume-to-suspend spacing at least 0.3 us; code accepts a suspend on any busy cycle
// RL14: Deep power-down reached within ten microseconds
// RL15: Power-down exit back to standby within thirty
// RL16: Page write busy, typical 0.25 ms
// RL17: Sector wipe busy, typical 30 ms
// RL18: Block wipe busy, typical 380 ms
// RL19: Chip wipe busy, typical 110 s
// RL20: Status write busy, at most 40 ms
// RL21: Host keeps serial clock rate limits
// RL22: Progress flag held over every timed interval; code leaves it low over the power-down entry and exit intervals
`timescale 1ns/1ps
`include "sfrr_regs.vh"
module sfrr_core #(
  parameter [39:0] CLEAR_MIN_CYC = `SFRR_CLEAR_MIN_CYC,
  parameter [39:0] REC_POWER_CYC = `SFRR_REC_POWER_US * `SFRR_CLK_MHZ,
  parameter [39:0] REC_READ_CYC  = `SFRR_REC_READ_US * `SFRR_CLK_MHZ,
  parameter [39:0] REC_DEC_CYC   = `SFRR_REC_DECODE_US * `SFRR_CLK_MHZ,
  parameter [39:0] REC_PROG_CYC  = `SFRR_REC_PROGRAM_US * `SFRR_CLK_MHZ,
  parameter [39:0] REC_SECT_CYC  = `SFRR_REC_SECTOR_MS * 1000 * `SFRR_CLK_MHZ,
  parameter [39:0] REC_BLK_CYC   = `SFRR_REC_BLOCK_MS * 1000 * `SFRR_CLK_MHZ,
  parameter [39:0] REC_CHIP_CYC  = `SFRR_REC_CHIP_MS * 1000 * `SFRR_CLK_MHZ,
  parameter [39:0] REC_STAT_CYC  = `SFRR_REC_STATUS_MS * 1000 * `SFRR_CLK_MHZ,
  parameter [39:0] PDN_ENTRY_CYC = `SFRR_PDN_ENTRY_CYC,
  parameter [39:0] PDN_EXIT_CYC  = `SFRR_PDN_EXIT_CYC,
  parameter [39:0] PAGE_CYC      = `SFRR_PAGE_TYP_US * `SFRR_CLK_MHZ,
  parameter [39:0] SECT_CYC      = 40'd7500000,
  parameter [39:0] BLK_CYC       = 40'd95000000,
  parameter [39:0] CHIP_CYC      = 40'd27500000000,
  parameter [39:0] STAT_CYC      = `SFRR_REC_STATUS_MS * 1000 * `SFRR_CLK_MHZ
) (
  // Clock and reset
  input  wire       mclk_i,
  input  wire       reset_n_i,
  // Pins from the host
  input  wire       clear_n_i,
  input  wire       select_n_i,
  input  wire       sclk_i,
  input  wire       supply_ok_i,
  // Decoded command from the command logic
  input  wire       cmd_valid_i,
  input  wire [2:0] cmd_op_i,
  input  wire       cmd_wren_i,
  input  wire       cmd_pdn_i,
  input  wire       cmd_pdn_exit_i,
  input  wire       cmd_suspend_i,
  input  wire       cmd_resume_i,
  input  wire       decoding_i,
  input  wire       reading_i,
  // Serial output from the data path
  input  wire       data_out_i,
  input  wire       data_drive_i,
  // Status
  output reg        write_enable_latch_o,
  output reg        write_in_progress_flag_o,
  output reg        lock_bit_o,
  output reg        erase_suspended_o,
  output reg        program_suspended_o,
  output reg        deep_power_down_o,
  output reg        in_reset_o,
  output reg        abort_o,
  output wire       cmd_ready_o,
  output reg        sclk_rise_o,
  // Serial data pin
  output reg        so_o,
  output wire       so_oe_o
);
  localparam ST_RECOVER = 3'h0;
  localparam ST_STANDBY = 3'h1;
  localparam ST_BUSY    = 3'h2;
  localparam ST_SUSPEND = 3'h3;
  localparam ST_PDN_IN  = 3'h4;
  localparam ST_PDN     = 3'h5;
  localparam ST_PDN_OUT = 3'h6;
  localparam ST_CLEAR   = 3'h7;

  wire [3:0] pins_s;
  wire       clear_n_s  = pins_s[0];
  wire       select_n_s = pins_s[1];
  wire       sclk_s     = pins_s[2];
  wire       supply_s   = pins_s[3];

  reg [2:0]  state;
  reg [2:0]  active_op;
  reg [2:0]  susp_op;
  reg [39:0] timer;
  reg [39:0] low_cnt;
  reg        select_n_d;
  reg        sclk_d;
  reg        pdn_pending;
  reg        exit_pending;

  // Recovery lookup, used for reset and for suspended erases
  function [39:0] rec_cycles;
    input [2:0] op;
    begin
      case (op)
        `SFRR_OP_READ:    rec_cycles = REC_READ_CYC;
        `SFRR_OP_DECODE:  rec_cycles = REC_DEC_CYC;
        `SFRR_OP_PROGRAM: rec_cycles = REC_PROG_CYC;
        `SFRR_OP_SECTOR:  rec_cycles = REC_SECT_CYC;
        `SFRR_OP_BLOCK:   rec_cycles = REC_BLK_CYC;
        `SFRR_OP_CHIP:    rec_cycles = REC_CHIP_CYC;
        `SFRR_OP_STATUS:  rec_cycles = REC_STAT_CYC;
        default:          rec_cycles = REC_POWER_CYC;
      endcase
    end
  endfunction

  function [39:0] busy_cycles;
    input [2:0] op;
    begin
      case (op)
        `SFRR_OP_PROGRAM: busy_cycles = PAGE_CYC; // RL16
        `SFRR_OP_SECTOR:  busy_cycles = SECT_CYC; // RL17
        `SFRR_OP_BLOCK:   busy_cycles = BLK_CYC; // RL18
        `SFRR_OP_CHIP:    busy_cycles = CHIP_CYC; // RL19
        `SFRR_OP_STATUS:  busy_cycles = STAT_CYC; // RL20
        default:          busy_cycles = 40'h1;
      endcase
    end
  endfunction

  function is_erase;
    input [2:0] op;
    begin
      is_erase = (op == `SFRR_OP_SECTOR) || (op == `SFRR_OP_BLOCK) ||
                 (op == `SFRR_OP_CHIP);
    end
  endfunction

  sfrr_sync u_sync (
    .mclk_i    (mclk_i),
    .reset_n_i (reset_n_i),
    .async_i   ({supply_ok_i, sclk_i, select_n_i, clear_n_i}),
    .sync_o    (pins_s)
  );

  // Activity the reset interrupts; a suspended erase takes precedence
  wire [2:0] cur_op = (state == ST_SUSPEND && is_erase(susp_op)) ? susp_op : // RL5
                      (state == ST_BUSY)    ? active_op :
                      (state == ST_SUSPEND) ? susp_op :
                      decoding_i ? `SFRR_OP_DECODE :
                      reading_i  ? `SFRR_OP_READ : `SFRR_OP_NONE;

  wire timer_done = (timer == 40'h1);
  wire select_rise = !select_n_d && select_n_s;
  wire hw_reset = (low_cnt >= CLEAR_MIN_CYC); // RL1
  // Ready only in standby or suspend with supply good; suspend and power-down exit bypass it
  assign cmd_ready_o = supply_s && (state == ST_STANDBY || state == ST_SUSPEND); // RL11
  wire take = cmd_valid_i && cmd_ready_o;

  // Tristated while the clear cycle runs
  assign so_oe_o = data_drive_i && (state != ST_CLEAR) && (state != ST_RECOVER) && supply_s; // RL4

  always @(posedge mclk_i) begin
    if (!reset_n_i) begin
      state                    <= ST_RECOVER;
      active_op                <= `SFRR_OP_NONE;
      susp_op                  <= `SFRR_OP_NONE;
      timer                    <= REC_POWER_CYC;
      low_cnt                  <= 40'h0;
      select_n_d               <= 1'b1;
      sclk_d                   <= 1'b0;
      pdn_pending              <= 1'b0;
      exit_pending             <= 1'b0;
      write_enable_latch_o     <= 1'b0; // RL8
      write_in_progress_flag_o <= 1'b1;
      lock_bit_o               <= 1'b0;
      erase_suspended_o        <= 1'b0;
      program_suspended_o      <= 1'b0;
      deep_power_down_o        <= 1'b0;
      in_reset_o               <= 1'b1;
      abort_o                  <= 1'b0;
      sclk_rise_o              <= 1'b0;
      so_o                     <= 1'b0;
    end else begin
      select_n_d  <= select_n_s;
      sclk_d      <= sclk_s;
      sclk_rise_o <= sclk_s && !sclk_d;
      so_o        <= data_out_i;
      abort_o     <= 1'b0;
      low_cnt     <= clear_n_s ? 40'h0 : (hw_reset ? low_cnt : low_cnt + 40'h1);
      if (timer != 40'h0)
        timer <= timer - 40'h1;
      if (!supply_s) begin
        // Low supply holds state, timer and status flags at power-on values
        state                    <= ST_RECOVER; // RL11
        timer                    <= REC_POWER_CYC;
        write_enable_latch_o     <= 1'b0;
        write_in_progress_flag_o <= 1'b1;
        lock_bit_o               <= 1'b0;
        erase_suspended_o        <= 1'b0;
        program_suspended_o      <= 1'b0;
        deep_power_down_o        <= 1'b0;
        in_reset_o               <= 1'b1;
        pdn_pending              <= 1'b0;
        exit_pending             <= 1'b0;
      end else if (hw_reset && state != ST_CLEAR) begin
        abort_o                  <= (state == ST_BUSY) || (state == ST_SUSPEND); // RL3
        state                    <= ST_CLEAR;
        active_op                <= cur_op;
        write_enable_latch_o     <= 1'b0; // RL2
        write_in_progress_flag_o <= 1'b1; // RL22
        lock_bit_o               <= 1'b0;
        erase_suspended_o        <= 1'b0;
        program_suspended_o      <= 1'b0;
        deep_power_down_o        <= 1'b0;
        in_reset_o               <= 1'b1;
        pdn_pending              <= 1'b0;
        exit_pending             <= 1'b0;
      end else begin
        case (state)
          ST_CLEAR: begin
            if (clear_n_s) begin
              state <= ST_RECOVER;
              timer <= rec_cycles(active_op); // RL6
            end
          end
          ST_RECOVER: begin
            if (timer_done || timer == 40'h0) begin
              state                    <= ST_STANDBY; // RL2
              write_in_progress_flag_o <= 1'b0; // RL22
              in_reset_o               <= 1'b0;
              active_op                <= `SFRR_OP_NONE;
            end
          end
          ST_STANDBY: begin
            if (take && cmd_wren_i)
              write_enable_latch_o <= 1'b1;
            else if (take && cmd_pdn_i)
              pdn_pending <= 1'b1;
            else if (take && cmd_op_i >= `SFRR_OP_PROGRAM && write_enable_latch_o) begin
              state                    <= ST_BUSY;
              active_op                <= cmd_op_i;
              timer                    <= busy_cycles(cmd_op_i);
              write_in_progress_flag_o <= 1'b1; // RL22
            end
            if (pdn_pending && select_rise) begin
              state       <= ST_PDN_IN;
              timer       <= PDN_ENTRY_CYC;
              pdn_pending <= 1'b0;
            end
          end
          ST_BUSY: begin
            // Ready only covers idle states, so suspend bypasses it here
            if (cmd_valid_i && cmd_suspend_i && active_op != `SFRR_OP_STATUS) begin
              state                    <= ST_SUSPEND;
              susp_op                  <= active_op;
              erase_suspended_o        <= is_erase(active_op);
              program_suspended_o      <= !is_erase(active_op);
              write_enable_latch_o     <= 1'b0;
              write_in_progress_flag_o <= 1'b0;
            end else if (timer_done) begin
              state                    <= ST_STANDBY;
              write_in_progress_flag_o <= 1'b0; // RL22
              write_enable_latch_o     <= 1'b0;
              active_op                <= `SFRR_OP_NONE;
            end
          end
          ST_SUSPEND: begin
            // Timer keeps the remaining time frozen
            timer <= timer;
            if (take && cmd_wren_i)
              write_enable_latch_o <= 1'b1;
            else if (take && cmd_resume_i) begin
              state                    <= ST_BUSY;
              erase_suspended_o        <= 1'b0;
              program_suspended_o      <= 1'b0;
              write_in_progress_flag_o <= 1'b1;
            end
          end
          ST_PDN_IN: begin
            if (timer_done) begin
              state             <= ST_PDN; // RL14
              deep_power_down_o <= 1'b1;
            end
          end
          ST_PDN: begin
            if (cmd_valid_i && cmd_pdn_exit_i)
              exit_pending <= 1'b1;
            if (exit_pending && select_rise) begin
              state        <= ST_PDN_OUT;
              timer        <= PDN_EXIT_CYC;
              exit_pending <= 1'b0;
            end
          end
          ST_PDN_OUT: begin
            if (timer_done) begin
              state             <= ST_STANDBY; // RL15
              deep_power_down_o <= 1'b0;
            end
          end
          default: state <= ST_RECOVER;
        endcase
      end
    end
  end
endmodule // sfrr_core

//--- testbench/sfrr_props.sv
`timescale 1ns/1ps
`include "sfrr_regs.vh"
module sfrr_props (
  // Clock and reset
  input logic       mclk_i,
  input logic       reset_n_i,
  // Inputs
  input logic       supply_ok_i,
  input logic       cmd_valid_i,
  input logic [2:0] cmd_op_i,
  // Outputs
  input logic       write_enable_latch_o,
  input logic       write_in_progress_flag_o,
  input logic       lock_bit_o,
  input logic       in_reset_o,
  input logic       abort_o,
  input logic       cmd_ready_o,
  input logic       so_oe_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  sequence prog_taken;
    cmd_valid_i && cmd_ready_o && cmd_op_i == `SFRR_OP_PROGRAM && write_enable_latch_o;
  endsequence
  sequence supply_low;
    !supply_ok_i [*4];
  endsequence
  a_reset_output_off: assert property (in_reset_o |-> !so_oe_o)
    else $error("data output driven during reset");
  a_reset_flag_held: assert property (in_reset_o |-> write_in_progress_flag_o)
    else $error("progress flag low during reset");
  a_reset_clears_bits: assert property (in_reset_o |-> !write_enable_latch_o && !lock_bit_o)
    else $error("volatile bits kept over reset");
  a_abort_single: assert property (abort_o |=> !abort_o)
    else $error("abort wider than one cycle");
  a_abort_enters_reset: assert property (abort_o |-> ##[0:3] in_reset_o)
    else $error("abort without reset");
  a_ready_means_idle: assert property (cmd_ready_o |-> !in_reset_o && !write_in_progress_flag_o)
    else $error("ready while busy");
  a_low_supply_blocks: assert property (supply_low |-> !cmd_ready_o)
    else $error("ready under low supply");
  a_program_busy_held: assert property (prog_taken |=> write_in_progress_flag_o [*8])
    else $error("program not flagged busy");
endmodule // sfrr_props
bind sfrr_core sfrr_props u_props (.mclk_i, .reset_n_i, .supply_ok_i, .cmd_valid_i, .cmd_op_i,
  .write_enable_latch_o, .write_in_progress_flag_o, .lock_bit_o, .in_reset_o, .abort_o,
  .cmd_ready_o, .so_oe_o);

//--- testbench/sfrr_host.sv
`timescale 1ns/1ps
module sfrr_host #(parameter int GAP = 8) (
  // Clock
  input  wire  mclk_i,
  // Pins to the device
  output logic clear_n_o,
  output logic select_n_o,
  output logic sclk_o
);
  initial begin
    clear_n_o  = 1'b1;
    select_n_o = 1'b1;
    sclk_o     = 1'b0;
  end
  // 8 MHz, still while deselected
  always #62.5 sclk_o = select_n_o ? 1'b0 : ~sclk_o;
  task automatic clear_pulse(input int n);
    @(posedge mclk_i);
    clear_n_o <= 1'b0;
    repeat (n) @(posedge mclk_i);
    clear_n_o <= 1'b1;
  endtask
  // Spacing of GAP master clock cycles before each select change
  task automatic set_select(input logic v);
    repeat (GAP) @(posedge mclk_i);
    select_n_o <= v;
  endtask
endmodule // sfrr_host

//--- testbench/serial_flash_reset_recovery_tb_top.sv
`timescale 1ns/1ps
`include "sfrr_regs.vh"
module serial_flash_reset_recovery_tb_top;
  localparam int CLR = 8, RP = 20, PG = 40, PE = 10, PX = 12;
  logic mclk = 0, reset_n = 0, supply_ok = 1, cmd_valid = 0, decoding = 0, reading = 0;
  logic wren = 0, pdn = 0, pex = 0, sus = 0, res = 0, dout = 1, ddrive = 1, abort_seen = 0;
  logic [2:0] op = 3'h0;
  wire clear_n, select_n, sclk, write_enable_latch, write_in_progress_flag, lock, esus, psus, dpd, inr, abt, rdy, srise, so, oe;
  wire [3:0] mon = {rdy, dpd, write_in_progress_flag, inr};
  int err_total = 0, n_compared = 0;
  int n_rise = 0;
  always #2 mclk = ~mclk;
  always @(posedge mclk) if (abt === 1'b1) abort_seen <= 1'b1;
  always @(posedge mclk) if (srise === 1'b1) n_rise <= n_rise + 1;
  sfrr_host u_host (.mclk_i(mclk), .clear_n_o(clear_n), .select_n_o(select_n), .sclk_o(sclk));
  sfrr_core #(.CLEAR_MIN_CYC(40'd8), .REC_POWER_CYC(40'd20), .REC_READ_CYC(40'd22),
    .REC_DEC_CYC(40'd24), .REC_PROG_CYC(40'd26), .REC_SECT_CYC(40'd28), .REC_BLK_CYC(40'd30),
    .REC_CHIP_CYC(40'd32), .REC_STAT_CYC(40'd34), .PDN_ENTRY_CYC(40'd10),
    .PDN_EXIT_CYC(40'd12), .PAGE_CYC(40'd40), .SECT_CYC(40'd44), .BLK_CYC(40'd48),
    .CHIP_CYC(40'd52), .STAT_CYC(40'd56)) u_dut (
    .mclk_i(mclk), .reset_n_i(reset_n), .clear_n_i(clear_n), .select_n_i(select_n),
    .sclk_i(sclk), .supply_ok_i(supply_ok), .cmd_valid_i(cmd_valid), .cmd_op_i(op),
    .cmd_wren_i(wren), .cmd_pdn_i(pdn), .cmd_pdn_exit_i(pex), .cmd_suspend_i(sus),
    .cmd_resume_i(res), .decoding_i(decoding), .reading_i(reading), .data_out_i(dout),
    .data_drive_i(ddrive), .write_enable_latch_o(write_enable_latch), .write_in_progress_flag_o(write_in_progress_flag),
    .lock_bit_o(lock), .erase_suspended_o(esus), .program_suspended_o(psus),
    .deep_power_down_o(dpd), .in_reset_o(inr), .abort_o(abt), .cmd_ready_o(rdy),
    .sclk_rise_o(srise), .so_o(so), .so_oe_o(oe));
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: got %0h want %0h", $time, seen, exp);
    end
  endtask
  task automatic in_range(input int n, input int lo, input int hi);
    check(40'(n >= lo && n <= hi), 40'd1);
  endtask
  // Bounded wait for one monitored output to reach a level
  task automatic wait_val(input int b, input logic v, output int n);
    n = 0;
    while (mon[b] !== v && n < 5000) begin
      @(posedge mclk);
      #1 n++;
    end
  endtask
  task automatic cmd(input logic [2:0] o, input logic [4:0] q);
    @(posedge mclk);
    cmd_valid <= 1'b1;
    op <= o;
    wren <= q[4];
    pdn <= q[3];
    pex <= q[2];
    sus <= q[1];
    res <= q[0];
    @(posedge mclk);
    cmd_valid <= 1'b0;
  endtask
  task automatic t_power_on;
    int n;
    wait_val(0, 1'b0, n);
    in_range(n, RP - 2, RP + 6);
    check({dpd, write_enable_latch, write_in_progress_flag}, 40'd0);
    check(n_rise, 0);
    @(posedge mclk);
    dout <= 1'b0;
    ddrive <= 1'b0;
    @(posedge mclk);
    #1 check({so, oe}, 40'd0);
    @(posedge mclk);
    dout <= 1'b1;
    ddrive <= 1'b1;
    @(posedge mclk);
    #1 check({so, oe}, 40'd3);
  endtask
  task automatic t_program;
    int n;
    cmd(3'h0, 5'b10000);
    cmd(`SFRR_OP_PROGRAM, 5'b0);
    @(posedge mclk);
    #1 check(write_in_progress_flag, 1);
    repeat (8) @(posedge mclk);
    cmd(3'h0, 5'b00010);
    @(posedge mclk);
    #1 check({psus, write_in_progress_flag, write_enable_latch}, 40'd4);
    cmd(3'h0, 5'b00001);
    @(posedge mclk);
    #1 check({psus, write_in_progress_flag}, 40'd1);
    // Time left is frozen over the suspend: 11 cycles ran before it
    wait_val(1, 1'b0, n);
    in_range(n, PG - 14, PG - 10);
    check(write_enable_latch, 0);
  endtask
  // Mode 0 busy, 1 erase suspended, 2 decoding, 3 reading
  task automatic t_reset_mid(input logic [2:0] o, input int mode, input int rec);
    int n;
    wait_val(3, 1'b1, n);
    if (mode < 2) cmd(3'h0, 5'b10000);
    if (mode < 2) cmd(o, 5'b0);
    if (mode == 1) begin
      repeat (8) @(posedge mclk);
      cmd(3'h0, 5'b00010);
    end
    @(posedge mclk);
    #1 if (mode == 1) check({esus, psus}, 40'd2);
    decoding <= (mode == 2);
    reading <= (mode == 3);
    abort_seen = 1'b0;
    u_host.clear_pulse(CLR + 4);
    #1 check(inr, 1);
    check(oe, 0);
    check(abort_seen, 40'(mode < 2));
    wait_val(0, 1'b0, n);
    in_range(n, rec, rec + 8);
    check({write_enable_latch, lock, write_in_progress_flag, esus, psus}, 40'd0);
    decoding <= 1'b0;
    reading <= 1'b0;
  endtask
  task automatic t_short_clear;
    u_host.clear_pulse(3);
    repeat (12) @(posedge mclk);
    #1 check(inr, 0);
  endtask
  task automatic t_power_down;
    int n, r0;
    u_host.set_select(1'b0);
    r0 = n_rise;
    // Selected long enough for at least one link clock rise
    repeat (40) @(posedge mclk);
    #1 check(40'(n_rise > r0), 40'd1);
    cmd(3'h0, 5'b01000);
    u_host.set_select(1'b1);
    wait_val(2, 1'b1, n);
    in_range(n, 0, PE + 4);
    u_host.set_select(1'b0);
    cmd(3'h0, 5'b00100);
    u_host.set_select(1'b1);
    wait_val(2, 1'b0, n);
    in_range(n, 0, PX + 4);
  endtask
  task automatic t_low_supply;
    int n;
    @(posedge mclk);
    supply_ok <= 1'b0;
    repeat (6) @(posedge mclk);
    #1 check(rdy, 0);
    cmd(3'h0, 5'b10000);
    @(posedge mclk);
    #1 check(write_enable_latch, 0);
    supply_ok <= 1'b1;
    wait_val(3, 1'b1, n);
    check(rdy, 1);
    in_range(n, RP, RP + 6);
  endtask
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    err_total++;
    report_and_stop;
  end
  initial begin
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    t_power_on;
    t_program;
    t_reset_mid(`SFRR_OP_PROGRAM, 0, 26);
    t_reset_mid(`SFRR_OP_SECTOR, 0, 28);
    t_reset_mid(`SFRR_OP_BLOCK, 0, 30);
    t_reset_mid(`SFRR_OP_CHIP, 0, 32);
    t_reset_mid(`SFRR_OP_STATUS, 0, 34);
    t_reset_mid(`SFRR_OP_SECTOR, 1, 28);
    t_reset_mid(3'h0, 2, 24);
    t_reset_mid(3'h0, 3, 22);
    t_short_clear;
    t_power_down;
    t_low_supply;
    report_and_stop;
  end
endmodule // serial_flash_reset_recovery_tb_top
